// ===== inc/lcd_if_pkg.sv
// Shared constants and types for the LCD host port and its byte FIFO
package lcd_if_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int BYTE_W     = 8;
  localparam int ENTRY_W    = BYTE_W + 1;
  localparam int FIFO_DEPTH = 8;
  localparam int BIT_CNT_W  = 3;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_CLEAR = 3'h0;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT      = 3'h7;
  localparam logic [BYTE_W-1:0]    BYTE_CLEAR    = 8'h00;
  localparam logic                 ENTRY_INSTR   = 1'b0;
  localparam logic                 ENTRY_DATA    = 1'b1;
  localparam logic                 STYLE_68      = 1'b1;
  localparam logic                 MODE_PARALLEL = 1'b1;

  // ----------------------------------------------------------------
  // Parallel access sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ACC_IDLE      = 5'h01,
    ACC_RD_DATA   = 5'h02,
    ACC_RD_STATUS = 5'h04,
    ACC_WR_DATA   = 5'h08,
    ACC_WR_INSTR  = 5'h10
  } access_e;

endpackage : lcd_if_pkg

// ===== rtl/byte_fifo.sv
// Small flop-based FIFO with a registered output stage
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               count;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } fifo_s;

  fifo_s q;
  fifo_s d;
  logic  push;
  logic  load;

  assign in_ready  = (q.count != CW'(DEPTH));
  assign out_valid = q.ov;
  assign out_data  = q.od;

  always_comb begin
    d    = q;
    push = in_valid && in_ready;
    // Output register refills from a non-empty store whenever it is empty or being drained
    load = (q.count != '0) && (!q.ov || out_ready);
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = PW'(q.wp + 1'b1);
    end
    if (load) begin
      d.ov = 1'b1;
      d.od = q.mem[q.rp];
      d.rp = PW'(q.rp + 1'b1);
    end else if (out_ready) begin
      d.ov = 1'b0;
    end
    d.count = CW'(q.count + CW'(push) - CW'(load));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : byte_fifo

`default_nettype wire

// ===== rtl/lcd_host_port.sv
// Host port of a bit-map LCD driver: parallel 68/80 bus, serial write link, bus holder
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Bus style select high means enable plus read/write; low means separate strobes.
// R2 - Serial data and clock count only when selected and serial mode chosen.
// R3 - Command select and direction pick data read/write, status read or instruction.
// R4 - Serial receiver is an eight-bit shift register and a three-bit counter.
// R5 - Shift register and counter stay cleared whenever the chip is deselected.
// R6 - Serial bits arrive most significant first, one per rising serial clock.
// R7 - Eighth serial edge hands over the byte and samples command select.
// R8 - A partial serial byte ended by deselect counts as instruction; one ended by external clear is dropped.
// R9 - Serial mode has no read path at all.
// R10 - Data read drives the holder, then reloads it from the addressed RAM word.
// R11 - Data write lands in the holder and is committed on the next cycle.
// R12 - Host does one dummy read after setting an address or writing.
// R13 - Host may pad slow accesses with no-operation cycles.
// R14 - Host accesses are answered only while chip select is low.
// R15 - Deselected: data lines float and all access inputs are ignored.
// R16 - External clear acts regardless of chip select.
// R17 - Data lines are driven only during a selected read.
module lcd_host_port
  import lcd_if_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      serial_clk,
  input  wire logic                      external_clear_n,
  input  wire logic                      cs_n,
  input  wire logic                      parallel_serial_select,
  input  wire logic                      bus_style_select,
  input  wire logic                      data_command_select,
  input  wire logic                      rd_n_or_enable,
  input  wire logic                      wr_n_or_read_write,
  input  wire logic [lcd_if_pkg::BYTE_W-1:0] parallel_data_bus_in,
  output logic [lcd_if_pkg::BYTE_W-1:0]  parallel_data_bus_out,
  output logic                           parallel_data_bus_oe,
  input  wire logic                      serial_data,
  input  wire logic [lcd_if_pkg::BYTE_W-1:0] status_byte,
  input  wire logic [lcd_if_pkg::BYTE_W-1:0] ram_byte,
  output logic                           ram_next,
  output logic                           overrun,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic [lcd_if_pkg::BYTE_W-1:0]  out_byte,
  output logic                           out_is_data
);

  import lcd_if_pkg::*;

  // ----------------------------------------------------------------
  // Serial link domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [BYTE_W-1:0]    shift;
    logic [BIT_CNT_W-1:0] cnt;
    logic                 first;
  } shift_s;

  // Hand-over words are not cleared by deselect, so the system side can
  // still read a partial byte after the frame has ended.
  typedef struct packed {
    logic [BYTE_W-1:0]    word;
    logic                 word_dc;
    logic                 byte_tgl;
    logic                 frame_tgl;
    logic [BYTE_W-1:0]    snap_byte;
    logic [BIT_CNT_W-1:0] snap_cnt;
  } link_s;

  shift_s sr_q;
  shift_s sr_d;
  link_s  lk_q;
  link_s  lk_d;
  logic   ser_clr;
  logic   link_clr;

  // Serial clock stops between frames, so clearing must be asynchronous
  assign ser_clr  = cs_n | parallel_serial_select | ~external_clear_n; // R2 R5 R16
  assign link_clr = ~external_clear_n;

  always_comb begin
    sr_d       = sr_q;
    lk_d       = lk_q;
    sr_d.shift = {sr_q.shift[BYTE_W-2:0], serial_data}; // R6
    sr_d.cnt   = BIT_CNT_W'(sr_q.cnt + 1'b1); // R4
    sr_d.first = 1'b0;
    // Edges seen while deselected or in parallel mode must not move the
    // hand-over words, or a stray frame toggle would fake a partial byte
    if (!ser_clr) begin // R2 R15
      lk_d.snap_byte = sr_d.shift;
      lk_d.snap_cnt  = sr_d.cnt;
      if (sr_q.first) begin
        lk_d.frame_tgl = ~lk_q.frame_tgl;
      end
      if (sr_q.cnt == LAST_BIT) begin
        lk_d.word     = sr_d.shift; // R7
        lk_d.word_dc  = data_command_select; // R7
        lk_d.byte_tgl = ~lk_q.byte_tgl;
      end
    end
  end

  always_ff @(posedge serial_clk or posedge ser_clr) begin
    if (ser_clr) begin
      sr_q <= '{shift: BYTE_CLEAR, cnt: BIT_CNT_CLEAR, first: 1'b1}; // R5
    end else begin
      sr_q <= sr_d;
    end
  end

  always_ff @(posedge serial_clk or posedge link_clr) begin
    if (link_clr) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              cs1, cs2, csp;
    logic              ps1, ps2;
    logic              sty1, sty2;
    logic              dc1, dc2;
    logic              rd1, rd2;
    logic              wr1, wr2;
    logic              clr1, clr2;
    logic [BYTE_W-1:0] bus1, bus2;
    logic              bt1, bt2, bt_seen;
    logic              fr1, fr2, fr_seen;
    access_e           state;
    logic [BYTE_W-1:0] holder;
    logic [BYTE_W-1:0] wr_byte;
    logic [BYTE_W-1:0] dout;
    logic              oe;
    logic              ram_next;
    logic              commit;
    logic              pend_v;
    logic              pend_dc;
    logic [BYTE_W-1:0] pend_byte;
    logic              overrun;
  } ctl_s;

  ctl_s              q;
  ctl_s              d;
  logic              par_sel;
  logic              rd_act;
  logic              wr_act;
  logic              fifo_in_ready;
  logic              new_v;
  logic              new_dc;
  logic [BYTE_W-1:0] new_byte;
  logic [ENTRY_W-1:0] fifo_out;

  assign par_sel = ~q.cs2 & (q.ps2 == MODE_PARALLEL); // R14 R15 R9
  assign rd_act  = (q.sty2 == STYLE_68) ? (q.rd2 & q.wr2) : ~q.rd2; // R1
  assign wr_act  = (q.sty2 == STYLE_68) ? (q.rd2 & ~q.wr2) : ~q.wr2; // R1

  always_comb begin
    d          = q;
    new_v      = 1'b0;
    new_dc     = ENTRY_INSTR;
    new_byte   = BYTE_CLEAR;
    // Two-stage synchronisers for every pin except serial clock and data, and for the link toggles
    d.cs1  = cs_n;
    d.cs2  = q.cs1;
    d.csp  = q.cs2;
    d.ps1  = parallel_serial_select;
    d.ps2  = q.ps1;
    d.sty1 = bus_style_select;
    d.sty2 = q.sty1;
    d.dc1  = data_command_select;
    d.dc2  = q.dc1;
    d.rd1  = rd_n_or_enable;
    d.rd2  = q.rd1;
    d.wr1  = wr_n_or_read_write;
    d.wr2  = q.wr1;
    d.clr1 = external_clear_n;
    d.clr2 = q.clr1;
    d.bus1 = parallel_data_bus_in;
    d.bus2 = q.bus1;
    d.bt1  = lk_q.byte_tgl;
    d.bt2  = q.bt1;
    d.fr1  = lk_q.frame_tgl;
    d.fr2  = q.fr1;
    d.ram_next = 1'b0;
    d.commit   = 1'b0;
    d.pend_v   = q.pend_v & ~fifo_in_ready;

    case (q.state)
      ACC_IDLE: begin
        d.oe = 1'b0;
        if (par_sel && rd_act) begin
          d.oe = 1'b1; // R17
          if (q.dc2) begin
            d.state = ACC_RD_DATA; // R3
            d.dout  = q.holder; // R10
          end else begin
            d.state = ACC_RD_STATUS; // R3
            d.dout  = status_byte;
          end
        end else if (par_sel && wr_act) begin
          d.state = q.dc2 ? ACC_WR_DATA : ACC_WR_INSTR; // R3
        end
      end
      ACC_RD_DATA, ACC_RD_STATUS: begin
        if (!(par_sel && rd_act)) begin
          d.state = ACC_IDLE;
          d.oe    = 1'b0; // R15 R17
          if (q.state == ACC_RD_DATA) begin
            d.holder   = ram_byte; // R10
            d.ram_next = 1'b1;
          end
        end
      end
      ACC_WR_DATA, ACC_WR_INSTR: begin
        // Keep the last byte seen inside the strobe; hold time is short
        d.wr_byte = q.bus2;
        if (!(par_sel && wr_act)) begin
          d.state = ACC_IDLE;
          if (q.state == ACC_WR_DATA) begin
            d.holder = q.wr_byte; // R11
            d.commit = 1'b1;
          end else begin
            new_v    = 1'b1;
            new_byte = q.wr_byte;
          end
        end
      end
      default: begin
        d.state = ACC_IDLE;
        d.oe    = 1'b0;
      end
    endcase

    if (q.commit) begin
      new_v    = 1'b1; // R11
      new_dc   = ENTRY_DATA;
      new_byte = q.holder;
    end else if (q.bt2 != q.bt_seen) begin
      d.bt_seen = q.bt2;
      new_v     = 1'b1; // R7
      new_dc    = lk_q.word_dc;
      new_byte  = lk_q.word;
    end else if (q.cs2 && !q.csp && (q.ps2 != MODE_PARALLEL)) begin
      d.fr_seen = q.fr2;
      if ((q.fr2 != q.fr_seen) && (lk_q.snap_cnt != BIT_CNT_CLEAR)) begin
        new_v    = 1'b1; // R8
        new_byte = lk_q.snap_byte;
      end
    end

    // A byte that finds the single pending slot busy is dropped and flagged
    if (new_v) begin
      if (d.pend_v) begin
        d.overrun = 1'b1;
      end else begin
        d.pend_v    = 1'b1;
        d.pend_dc   = new_dc;
        d.pend_byte = new_byte;
      end
    end

    if (!q.clr2) begin
      d.state    = ACC_IDLE; // R16
      d.oe       = 1'b0;
      d.holder   = BYTE_CLEAR;
      d.commit   = 1'b0;
      d.ram_next = 1'b0;
      d.pend_v   = 1'b0;
      d.overrun  = 1'b0;
      // Link toggles are cleared too; follow them so no false byte appears
      d.bt_seen  = 1'b0;
      d.fr_seen  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q       <= '0;
      q.state <= ACC_IDLE;
      // Chip select idles high; a zero here would fake a deselect edge
      q.cs1   <= 1'b1;
      q.cs2   <= 1'b1;
      q.csp   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Output buffering
  // ----------------------------------------------------------------
  byte_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (q.pend_v),
    .in_ready  (fifo_in_ready),
    .in_data   ({q.pend_dc, q.pend_byte}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_is_data           = fifo_out[BYTE_W];
  assign out_byte              = fifo_out[BYTE_W-1:0];
  assign parallel_data_bus_out = q.dout;
  assign parallel_data_bus_oe  = q.oe;
  assign ram_next              = q.ram_next;
  assign overrun               = q.overrun;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_drive_needs_read;
    $rose(parallel_data_bus_oe) |-> $past(par_sel && rd_act);
  endproperty
  a_drive_needs_read: assert property (p_drive_needs_read) // R17
    else $error("data bus driven without a selected read");

  property p_float_deselected;
    q.cs2 |=> !parallel_data_bus_oe;
  endproperty
  a_float_deselected: assert property (p_float_deselected) // R15
    else $error("data bus driven while deselected");

  property p_serial_never_reads;
    (q.ps2 != MODE_PARALLEL) |=> !parallel_data_bus_oe;
  endproperty
  a_serial_never_reads: assert property (p_serial_never_reads) // R9
    else $error("data bus driven in serial mode");

  property p_style68_enable_low;
    (q.sty2 == STYLE_68) && !q.rd2 && q.clr2 |=> !parallel_data_bus_oe;
  endproperty
  a_style68_enable_low: assert property (p_style68_enable_low) // R1
    else $error("68-style read driven with enable low");

  property p_read_shows_holder;
    $rose(parallel_data_bus_oe) && q.state == ACC_RD_DATA
      |-> parallel_data_bus_out == $past(q.holder);
  endproperty
  a_read_shows_holder: assert property (p_read_shows_holder) // R10
    else $error("data read did not show the bus holder");

  property p_read_reloads_holder;
    q.state == ACC_RD_DATA && !(par_sel && rd_act) && q.clr2
      |=> ram_next && q.holder == $past(ram_byte) ##1 !ram_next;
  endproperty
  a_read_reloads_holder: assert property (p_read_reloads_holder) // R10
    else $error("holder not reloaded after data read");

  property p_write_commits;
    q.state == ACC_WR_DATA && !(par_sel && wr_act) && q.clr2 && !q.pend_v
      ##1 q.clr2 |=> (q.pend_v && q.pend_dc == ENTRY_DATA) || q.overrun;
  endproperty
  a_write_commits: assert property (p_write_commits) // R11
    else $error("data write not committed on the next cycle");

  property p_instr_decoded;
    q.state == ACC_WR_INSTR && !(par_sel && wr_act) && q.clr2 && !q.pend_v && !q.commit
      |=> q.pend_v && q.pend_dc == ENTRY_INSTR && q.pend_byte == $past(q.wr_byte);
  endproperty
  a_instr_decoded: assert property (p_instr_decoded) // R3
    else $error("instruction write decoded wrongly");

  property p_clear_any_select;
    !q.clr2 |=> q.state == ACC_IDLE && !parallel_data_bus_oe && !q.pend_v;
  endproperty
  a_clear_any_select: assert property (p_clear_any_select) // R16
    else $error("external clear ignored");

  property p_counter_cleared;
    q.cs2 && q.csp |-> sr_q.cnt == BIT_CNT_CLEAR && sr_q.shift == BYTE_CLEAR;
  endproperty
  a_counter_cleared: assert property (p_counter_cleared) // R5
    else $error("serial receiver not cleared while deselected");

  property p_msb_first;
    @(posedge serial_clk) disable iff (ser_clr)
      !sr_q.first |-> sr_q.shift[0] == $past(serial_data)
        && sr_q.shift[BYTE_W-1:1] == $past(sr_q.shift[BYTE_W-2:0]);
  endproperty
  a_msb_first: assert property (p_msb_first) // R6
    else $error("serial shift order wrong");

  property p_eighth_edge;
    @(posedge serial_clk) disable iff (ser_clr)
      sr_q.cnt == LAST_BIT |=> lk_q.word == $past(sr_d.shift)
        && lk_q.byte_tgl != $past(lk_q.byte_tgl) && sr_q.cnt == BIT_CNT_CLEAR;
  endproperty
  a_eighth_edge: assert property (p_eighth_edge) // R4
    else $error("byte not handed over on the eighth edge");

  property p_serial_byte_queued;
    q.bt2 != q.bt_seen && !q.commit && q.clr2 && !q.pend_v
      |=> q.pend_v && q.pend_byte == lk_q.word && q.pend_dc == lk_q.word_dc;
  endproperty
  a_serial_byte_queued: assert property (p_serial_byte_queued) // R7
    else $error("serial byte not queued");

  c_data_read:   cover property (q.state == ACC_RD_DATA ##[1:20] ram_next);
  c_data_commit: cover property (q.commit && q.pend_dc == ENTRY_DATA);
  c_serial_byte: cover property (q.bt2 != q.bt_seen);
  c_partial:     cover property (q.cs2 && !q.csp && q.fr2 != q.fr_seen
                                 && lk_q.snap_cnt != BIT_CNT_CLEAR);

endmodule : lcd_host_port

`default_nettype wire

// ===== testbench/mpu_model.sv
// Host processor model: 68/80 parallel bus cycles and the serial write link
`timescale 1ns/1ps
`default_nettype none

module mpu_model
  import lcd_if_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic [lcd_if_pkg::BYTE_W-1:0] bus_out,
  input  wire logic                          bus_oe,
  output wire logic [lcd_if_pkg::BYTE_W-1:0] bus_in,
  output var logic                           cs_n,
  output var logic                           ps_sel,
  output var logic                           style_sel,
  output var logic                           dc_sel,
  output var logic                           strobe_a,
  output var logic                           strobe_b,
  output var logic                           serial_clk,
  output var logic                           serial_data
);
  import lcd_if_pkg::*;

  logic              host_drv;
  logic [BYTE_W-1:0] host_byte;
  logic [BYTE_W-1:0] last_q;

  // --------------------------------------------------------------
  // Bus wire
  // --------------------------------------------------------------
  // A released bus shows a changing pattern, never the last value
  assign bus_in = bus_oe ? bus_out : (host_drv ? host_byte : ~last_q);

  always @(posedge clk) begin
    last_q <= bus_in;
  end

  initial begin
    cs_n = 1'b1; ps_sel = 1'b1; style_sel = 1'b0; dc_sel = 1'b0;
    strobe_a = 1'b1; strobe_b = 1'b1; serial_clk = 1'b0; serial_data = 1'b0;
    host_drv = 1'b0; host_byte = BYTE_CLEAR; last_q = BYTE_CLEAR;
  end

  // --------------------------------------------------------------
  // Parallel cycle: strobe low/high spans kept at 4 clocks or more
  // --------------------------------------------------------------
  task automatic par(input logic sel, input logic ps, input logic style, input logic dc,
                     input logic rd, input logic [BYTE_W-1:0] val);
    @(posedge clk);
    cs_n      <= ~sel;
    ps_sel    <= ps;
    style_sel <= style;
    dc_sel    <= dc;
    strobe_a  <= ~style;
    strobe_b  <= style ? rd : 1'b1;
    host_byte <= val;
    host_drv  <= ~rd;
    repeat (4) @(posedge clk);
    if (style) begin
      strobe_a <= 1'b1;
    end else if (rd) begin
      strobe_a <= 1'b0;
    end else begin
      strobe_b <= 1'b0;
    end
    repeat (4) @(posedge clk);
    strobe_a <= ~style;
    strobe_b <= style ? rd : 1'b1;
    repeat (2) @(posedge clk);
    host_drv <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
  endtask : par

  // --------------------------------------------------------------
  // Serial frame: the link clock runs only inside the frame
  // --------------------------------------------------------------
  task automatic ser(input logic ps, input int nbits, input logic dc,
                     input logic [BYTE_W-1:0] val);
    @(posedge clk);
    cs_n   <= 1'b0;
    ps_sel <= ps;
    dc_sel <= dc;
    repeat (4) @(posedge clk);
    #3;
    for (int i = 7; i > 7 - nbits; i--) begin
      serial_data = val[i];
      #7.5 serial_clk = 1'b1;
      #7.5 serial_clk = 1'b0;
    end
    serial_data = ~serial_data;
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : ser
endmodule : mpu_model

`default_nettype wire

// ===== testbench/lcd_driver_mpu_interface_bench.sv
// Self-checking bench for the LCD host port
`timescale 1ns/1ps
`default_nettype none

module lcd_driver_mpu_interface_bench;
  import lcd_if_pkg::*;

  logic               clk, rst, ext_clr_n, out_ready, stall, oe_seen;
  logic [BYTE_W-1:0]  status_byte, ram_byte, v, r;
  wire logic [BYTE_W-1:0] bus_in, bus_out, out_byte;
  wire logic          bus_oe, cs_n, ps_sel, style_sel, dc_sel, strobe_a, strobe_b;
  wire logic          serial_clk, serial_data, ram_next, overrun, out_valid, out_is_data;
  logic [ENTRY_W-1:0] exp_q[$];
  logic [BYTE_W-1:0]  rd_q[$];
  int                 num_errors, checked;
  int                 ram_pulses = 0;

  mpu_model i_mpu (.clk(clk), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in),
    .cs_n(cs_n), .ps_sel(ps_sel), .style_sel(style_sel), .dc_sel(dc_sel),
    .strobe_a(strobe_a), .strobe_b(strobe_b), .serial_clk(serial_clk),
    .serial_data(serial_data));

  lcd_host_port i_dut (.clk(clk), .rst(rst), .serial_clk(serial_clk),
    .external_clear_n(ext_clr_n), .cs_n(cs_n), .parallel_serial_select(ps_sel),
    .bus_style_select(style_sel), .data_command_select(dc_sel),
    .rd_n_or_enable(strobe_a), .wr_n_or_read_write(strobe_b),
    .parallel_data_bus_in(bus_in), .parallel_data_bus_out(bus_out),
    .parallel_data_bus_oe(bus_oe), .serial_data(serial_data),
    .status_byte(status_byte), .ram_byte(ram_byte), .ram_next(ram_next),
    .overrun(overrun), .out_valid(out_valid), .out_ready(out_ready),
    .out_byte(out_byte), .out_is_data(out_is_data));

  // --------------------------------------------------------------
  // Clock, sink and checking
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    out_ready <= stall ? 1'b0 : 1'($urandom_range(1, 0));
  end

  task automatic check(input logic [ENTRY_W-1:0] seen, input logic [ENTRY_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Comparisons: %0d, mismatches: %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Any output without a pending note is itself a mismatch
  always @(posedge clk) begin
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) check(9'h1FF, 9'h000);
      else check({out_is_data, out_byte}, exp_q.pop_front());
    end
    if (!rst && bus_oe === 1'b1 && oe_seen !== 1'b1) begin
      if (rd_q.size() == 0) check(9'h1FF, 9'h000);
      else check({1'b0, bus_out}, {1'b0, rd_q.pop_front()});
    end
    if (!rst && ram_next === 1'b1) ram_pulses++;
    oe_seen <= bus_oe;
  end

  initial begin
    #100us;
    num_errors++;
    report_and_stop();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1; ext_clr_n = 1'b1; stall = 1'b0;
    status_byte = BYTE_CLEAR; ram_byte = BYTE_CLEAR; v = BYTE_CLEAR; r = BYTE_CLEAR;
    num_errors = 0; checked = 0;
    void'($urandom(32'hC7B4));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    for (int s = 0; s < 2; s++) begin
      for (int d = 0; d < 2; d++) begin
        v = 8'($urandom);
        exp_q.push_back({d[0], v});
        i_mpu.par(1'b1, 1'b1, s[0], d[0], 1'b0, v);
      end
    end
    r = 8'($urandom);
    ram_byte <= r;
    rd_q.push_back(v);
    i_mpu.par(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
    ram_byte <= ~r;
    rd_q.push_back(r);
    i_mpu.par(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
    v = 8'($urandom);
    status_byte <= v;
    rd_q.push_back(v);
    i_mpu.par(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
    i_mpu.par(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
    i_mpu.par(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h5A);
    i_mpu.par(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    for (int d = 0; d < 2; d++) begin
      v = 8'($urandom);
      exp_q.push_back({d[0], v});
      i_mpu.ser(1'b0, 8, d[0], v);
    end
    i_mpu.ser(1'b1, 8, 1'b1, 8'hA5);
    v = 8'($urandom);
    exp_q.push_back({ENTRY_INSTR, 5'h00, v[7:5]});
    i_mpu.ser(1'b0, 3, 1'b1, v);
    ext_clr_n <= 1'b0;
    i_mpu.ser(1'b0, 3, 1'b0, v);
    ext_clr_n <= 1'b1;
    repeat (6) @(posedge clk);
    // Ten entries fit: eight in the store, the output stage and the pending slot
    stall <= 1'b1;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      v = 8'($urandom);
      if (i < 10) exp_q.push_back({ENTRY_INSTR, v});
      i_mpu.par(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, v);
    end
    repeat (6) @(posedge clk);
    check({8'h00, overrun}, 9'h001);
    stall <= 1'b0;
    repeat (60) @(posedge clk);
    ext_clr_n <= 1'b0;
    repeat (4) @(posedge clk);
    ext_clr_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({8'h00, overrun}, 9'h000);
    check({8'h00, exp_q.size() == 0}, 9'h001);
    check({8'h00, rd_q.size() == 0}, 9'h001);
    check(9'(ram_pulses), 9'h002);
    report_and_stop();
  end
endmodule : lcd_driver_mpu_interface_bench

`default_nettype wire
